// File: src/dbd_ack_timer.sv
// automatic data acknowledge wait-state counter
// assumes: start is a one-cycle pulse; stop is the end of the bus cycle
`timescale 1ns/100ps
module dbd_ack_timer
    import dbd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic auto_i,
    input wire logic [3:0] waits_i,
    input wire logic stop_i,
    output logic ack_o
);
    logic [3:0] cnt_q;
    logic run_q;
    logic ack_q;

    // ---------------------------------------------------------------
    // count down the wait states, then hold ack until the cycle ends
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i || stop_i)
        begin
            run_q <= 1'b0;
            cnt_q <= 4'h0;
        end
        else if (start_i)
        begin
            run_q <= auto_i; // no run means external ack is expected
            cnt_q <= waits_i;
        end
        else if (run_q && cnt_q != 4'h0)
        begin
            cnt_q <= cnt_q - 4'h1;
        end
        else
        begin
            run_q <= 1'b0;
        end
    end

    // ack rises one edge after the count reaches zero; a restart drops it
    always_ff @(posedge clk_i)
    begin
        if (rst_i || stop_i || start_i)
        begin
            ack_q <= 1'b0;
        end
        else if (run_q && cnt_q == 4'h0)
        begin
            ack_q <= 1'b1;
        end
    end

    assign ack_o = ack_q;

endmodule : dbd_ack_timer

// File: src/dbd_bank_decode.sv
// dram bank decode and automatic acknowledge, with ahb-lite register slave
// assumes: core bus signals share SYS_CLK_I; chip select hits come decoded
//
// Behaviour
// - read permit bit gates bank reads
// - no read nor write permit disables bank
// - per-code enables for codes 6, 5, 2, 1
// - no code enabled disables bank
// - match count compares top address bits
// - column bits equal eight plus size field
// - size and wait come from bank 0
// - wait bit gives zero or one wait
// - dram test-and-set write half is zero-wait
// - separate ack settings, chip selects 0-14 or external
// - chip select test-and-set write like normal write
// - write permit bit gates bank writes
// - bank configuration survives every reset
// - chip selects beat bank 0, bank 0 beats 1
// - upper word holds compared base bits
`timescale 1ns/100ps
module dbd_bank_decode
    import dbd_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    // ahb-lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [3:0] HPROT_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // processor bus cycle
    input wire logic [31:0] CYC_ADDR_I,
    input wire logic [2:0] CYC_FC_I,
    input wire logic CYC_READ_I,
    input wire logic CYC_ADDRESS_STROBE_N_I,
    input wire logic CYC_TEST_AND_SET_I,
    input wire logic [7:0] CS_HIT_I,
    // dram and acknowledge side
    output logic [1:0] BANK_SEL_O,
    output logic [3:0] DRAM_COL_BITS_O,
    output logic DRAM_WAIT_O,
    output logic DATA_TRANSFER_ACK_N_O,
    output logic CYC_REFUSED_O
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [15:0] cfg_low_q [2];
    logic [15:0] cfg_high_q [2];
    logic [31:0] cs_ack_q;
    logic wr_pend_q;
    logic [31:0] wr_addr_q;
    logic addr_phase;
    logic priv;
    logic [31:0] rd_word;
    logic [1:0] bank_hit;
    logic cs_any;
    logic [2:0] cs_idx;
    dbd_space_t space;
    dbd_space_t space_q;
    logic as_now;
    logic as_prev_q;
    logic read_prev_q;
    logic cyc_start;
    logic rmw_write_start;
    logic start;
    logic auto_en;
    logic [3:0] waits;
    logic ack;
    logic refused_q;
    logic [1:0] bank_sel_q;

    // ---------------------------------------------------------------
    // ahb-lite slave
    // ---------------------------------------------------------------
    // every access completes at once with an okay response
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign addr_phase = HSEL_I && HTRANS_I[1] && HREADY_I;
    // user-mode accesses read zero and write nothing
    assign priv = HPROT_I[1];

    // hold a write over to its data phase, when hwdata arrives
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h00000000;
        end
        else
        begin
            wr_pend_q <= addr_phase && HWRITE_I && priv;
            wr_addr_q <= HADDR_I;
        end
    end

    // bank words carry no reset so a warm restart keeps the memory map
    always_ff @(posedge SYS_CLK_I)
    begin
        if (wr_pend_q)
        begin
            unique case (wr_addr_q)
                ADDR_LOW_B0: cfg_low_q[0] <= HWDATA_I[15:0];
                ADDR_LOW_B1: cfg_low_q[1] <= HWDATA_I[15:0];
                ADDR_HIGH_B0: cfg_high_q[0] <= HWDATA_I[15:0];
                ADDR_HIGH_B1: cfg_high_q[1] <= HWDATA_I[15:0];
                default: ;
            endcase
        end
    end

    // chip select ack settings: one nibble per select, external by default
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            cs_ack_q <= CS_ACK_RESET;
        end
        else if (wr_pend_q && wr_addr_q == ADDR_CS_ACK)
        begin
            cs_ack_q <= HWDATA_I;
        end
    end

    // read mux; the status word shows the registered decode of the bus cycle
    always_comb
    begin
        rd_word = 32'h00000000;
        unique case (HADDR_I)
            ADDR_LOW_B0: rd_word = {16'h0000, cfg_low_q[0]};
            ADDR_LOW_B1: rd_word = {16'h0000, cfg_low_q[1]};
            ADDR_HIGH_B0: rd_word = {16'h0000, cfg_high_q[0]};
            ADDR_HIGH_B1: rd_word = {16'h0000, cfg_high_q[1]};
            ADDR_CS_ACK: rd_word = cs_ack_q;
            ADDR_STATUS: rd_word = {27'h0000000, ~as_prev_q, ack, refused_q, bank_sel_q};
            default: rd_word = 32'h00000000;
        endcase
    end

    // read data is fetched in the address phase so it stands from a flop
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            HRDATA_O <= 32'h00000000;
        end
        else if (addr_phase && !HWRITE_I)
        begin
            HRDATA_O <= priv ? rd_word : 32'h00000000;
        end
    end

    // ---------------------------------------------------------------
    // bank qualification
    // ---------------------------------------------------------------
    genvar gb;
    generate
        for (gb = 0; gb < 2; gb = gb + 1)
        begin : g_bank
            dbd_bank_match u_match (
                .cfg_low_i(cfg_low_q[gb]),
                .cfg_high_i(cfg_high_q[gb]),
                .addr_i(CYC_ADDR_I),
                .fc_i(CYC_FC_I),
                .read_i(CYC_READ_I),
                .hit_o(bank_hit[gb])
            );
        end
    endgenerate

    // lowest numbered chip select that hits owns the ack setting
    always_comb
    begin
        cs_idx = 3'h0;
        for (int i = NUM_CS - 1; i >= 0; i--)
        begin
            if (CS_HIT_I[i])
            begin
                cs_idx = 3'(i);
            end
        end
    end
    assign cs_any = |CS_HIT_I;

    // overlapping decodes: chip selects first, then bank 0, then bank 1
    always_comb
    begin
        if (cs_any)
        begin
            space = SPACE_CS;
        end
        else if (bank_hit[0])
        begin
            space = SPACE_BANK0;
        end
        else if (bank_hit[1])
        begin
            space = SPACE_BANK1;
        end
        else
        begin
            space = SPACE_NONE;
        end
    end

    // ---------------------------------------------------------------
    // cycle framing
    // ---------------------------------------------------------------
    assign as_now = ~CYC_ADDRESS_STROBE_N_I;

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            as_prev_q <= 1'b0;
            read_prev_q <= 1'b1;
        end
        else
        begin
            as_prev_q <= as_now;
            read_prev_q <= CYC_READ_I;
        end
    end

    // strobe stays low across an indivisible cycle, so the write half
    // is found by the direction turning from read to write
    assign cyc_start = as_now && !as_prev_q;
    assign rmw_write_start = as_now && as_prev_q && CYC_TEST_AND_SET_I
        && read_prev_q && !CYC_READ_I;
    assign start = cyc_start || rmw_write_start;

    // space is latched at each half's start and held until the strobe rises
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I || !as_now)
        begin
            space_q <= SPACE_NONE;
            refused_q <= 1'b0;
            bank_sel_q <= 2'b00;
        end
        else if (start)
        begin
            space_q <= space;
            refused_q <= (space == SPACE_NONE);
            bank_sel_q <= {space == SPACE_BANK1, space == SPACE_BANK0};
        end
    end

    // ---------------------------------------------------------------
    // automatic acknowledge setting for the selected space
    // ---------------------------------------------------------------
    always_comb
    begin
        auto_en = 1'b0;
        waits = 4'h0;
        unique case (space)
            SPACE_CS:
            begin
                // the write half keeps the plain write length
                waits = cs_ack_q[{cs_idx, 2'b00} +: 4];
                auto_en = (waits != CS_ACK_EXTERNAL);
            end
            SPACE_BANK0, SPACE_BANK1:
            begin
                auto_en = 1'b1;
                // bank 1 wait bit is ignored; both banks share speed
                if (rmw_write_start)
                begin
                    waits = DRAM_RMW_WRITE_WAITS;
                end
                else
                begin
                    waits = {3'h0, cfg_low_q[0][LOW_WAIT_BIT]};
                end
            end
            SPACE_NONE:
            begin
                auto_en = 1'b0;
                waits = 4'h0;
            end
        endcase
    end

    dbd_ack_timer u_ack (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .start_i(start),
        .auto_i(auto_en),
        .waits_i(waits),
        .stop_i(!as_now),
        .ack_o(ack)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign DATA_TRANSFER_ACK_N_O = ~ack;
    assign CYC_REFUSED_O = refused_q;
    assign BANK_SEL_O = bank_sel_q;
    // multiplexer width and wait follow bank 0 alone
    assign DRAM_COL_BITS_O = COL_BITS_BASE
        + {1'b0, cfg_low_q[0][LOW_SIZE_LSB +: 3]};
    assign DRAM_WAIT_O = cfg_low_q[0][LOW_WAIT_BIT];

endmodule : dbd_bank_decode

// File: src/dbd_bank_match.sv
// one dram bank: permission, function code and base address qualification
// assumes: configuration words are stable while a cycle is decoded
`timescale 1ns/100ps
module dbd_bank_match
    import dbd_pkg::*;
(
    input wire logic [15:0] cfg_low_i,
    input wire logic [15:0] cfg_high_i,
    input wire logic [31:0] addr_i,
    input wire logic [2:0] fc_i,
    input wire logic read_i,
    output logic hit_o
);
    logic [BASE_BITS-1:0] mask;
    logic [BASE_BITS-1:0] base;
    logic [3:0] count;
    logic fc_ok;
    logic dir_ok;
    logic disabled;

    // ---------------------------------------------------------------
    // compare mask: count selects top bits from a31 downward
    // ---------------------------------------------------------------
    assign count = cfg_low_i[LOW_MATCH_LSB +: 4];
    assign base = cfg_high_i[HIGH_BASE_LSB +: BASE_BITS];
    genvar gi;
    generate
        for (gi = 0; gi < BASE_BITS; gi = gi + 1)
        begin : g_mask
            // bit gi stands for address bit a17+gi
            assign mask[gi] = ({1'b0, count} >= 5'(BASE_BITS - gi));
        end
    endgenerate

    // only codes 6, 5, 2 and 1 have enables; all others are refused
    always_comb
    begin
        unique case (fc_i)
            FC_6: fc_ok = cfg_low_i[LOW_FC6_BIT];
            FC_5: fc_ok = cfg_low_i[LOW_FC5_BIT];
            FC_2: fc_ok = cfg_low_i[LOW_FC2_BIT];
            FC_1: fc_ok = cfg_low_i[LOW_FC1_BIT];
            default: fc_ok = 1'b0;
        endcase
    end

    // read and write permission per direction
    assign dir_ok = read_i ? cfg_low_i[LOW_READ_BIT] : cfg_high_i[HIGH_WRITE_BIT];

    // whole bank off: no direction, no code, or stray base bits set
    assign disabled = ~(cfg_low_i[LOW_READ_BIT] | cfg_high_i[HIGH_WRITE_BIT])
        | ~(cfg_low_i[LOW_FC6_BIT] | cfg_low_i[LOW_FC5_BIT]
            | cfg_low_i[LOW_FC2_BIT] | cfg_low_i[LOW_FC1_BIT])
        | (|(base & ~mask));

    assign hit_o = ~disabled & fc_ok & dir_ok
        & ~(|((addr_i[31:17] ^ base) & mask));

endmodule : dbd_bank_match

// File: src/dbd_pkg.sv
// dram bank decode package: register map, field positions and ack constants
// assumes: shared by the bank decoder, the ack timer and the top module
package dbd_pkg;

    // ---------------------------------------------------------------
    // register indices as printed; byte address is four times index
    // ---------------------------------------------------------------
    localparam logic [31:0] CFG_LOW_IDX_B0 = 32'hffffffe2;
    localparam logic [31:0] CFG_LOW_IDX_B1 = 32'h0fffffe6;
    localparam logic [31:0] CFG_HIGH_IDX_B0 = 32'h0fffffe0;
    localparam logic [31:0] CFG_HIGH_IDX_B1 = 32'h0fffffe4;
    localparam logic [31:0] ADDR_LOW_B0 = {CFG_LOW_IDX_B0[29:0], 2'b00};
    localparam logic [31:0] ADDR_LOW_B1 = {CFG_LOW_IDX_B1[29:0], 2'b00};
    localparam logic [31:0] ADDR_HIGH_B0 = {CFG_HIGH_IDX_B0[29:0], 2'b00};
    localparam logic [31:0] ADDR_HIGH_B1 = {CFG_HIGH_IDX_B1[29:0], 2'b00};
    localparam logic [31:0] ADDR_STATUS = 32'h00000000;
    localparam logic [31:0] ADDR_CS_ACK = 32'h00000004;

    // ---------------------------------------------------------------
    // lower configuration word fields
    // ---------------------------------------------------------------
    localparam int LOW_READ_BIT = 15;
    localparam int LOW_FC6_BIT = 14;
    localparam int LOW_FC5_BIT = 13;
    localparam int LOW_FC2_BIT = 10;
    localparam int LOW_FC1_BIT = 9;
    localparam int LOW_MATCH_LSB = 4;
    localparam int LOW_SIZE_LSB = 1;
    localparam int LOW_WAIT_BIT = 0;

    // upper configuration word: base bits a31..a17 at 15:1, write permit at 0
    localparam int HIGH_BASE_LSB = 1;
    localparam int HIGH_WRITE_BIT = 0;
    localparam int BASE_BITS = 15;

    // ---------------------------------------------------------------
    // function codes, column width and acknowledge settings
    // ---------------------------------------------------------------
    localparam logic [2:0] FC_1 = 3'h1;
    localparam logic [2:0] FC_2 = 3'h2;
    localparam logic [2:0] FC_5 = 3'h5;
    localparam logic [2:0] FC_6 = 3'h6;
    localparam logic [3:0] COL_BITS_BASE = 4'h8;
    localparam int NUM_CS = 8;
    localparam logic [3:0] CS_ACK_EXTERNAL = 4'hf;
    localparam logic [31:0] CS_ACK_RESET = 32'hffffffff;
    localparam logic [3:0] DRAM_RMW_WRITE_WAITS = 4'h0;

    typedef enum logic [1:0] {SPACE_NONE, SPACE_CS, SPACE_BANK0, SPACE_BANK1} dbd_space_t;

endpackage : dbd_pkg

// File: verification/dbd_bank_decode_assertions.sv
// checker for the bank decoder: cycle answers and bank geometry
// assumes: bound to dbd_bank_decode, one clock, synchronous reset
`timescale 1ns/100ps
module dbd_bank_decode_chk
    import dbd_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [3:0] HPROT_I,
    input wire logic HREADY_I,
    input wire logic CYC_ADDRESS_STROBE_N_I,
    input wire logic CYC_READ_I,
    input wire logic CYC_TEST_AND_SET_I,
    input wire logic [7:0] CS_HIT_I,
    input wire logic [1:0] BANK_SEL_O,
    input wire logic [3:0] DRAM_COL_BITS_O,
    input wire logic DRAM_WAIT_O,
    input wire logic DATA_TRANSFER_ACK_N_O,
    input wire logic CYC_REFUSED_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RESET_I);

    // ----
    // helper: privileged write to bank 0 low word
    // ----
    // flags the data-phase edge; seen gates out the unwritten word
    logic b0_wr_q = 1'b0;
    logic b0_seen_q = 1'b0;
    always_ff @(posedge SYS_CLK_I)
    begin
        b0_wr_q <= HSEL_I & HTRANS_I[1] & HWRITE_I & HREADY_I & HPROT_I[1]
                   & (HADDR_I == ADDR_LOW_B0);
        b0_seen_q <= b0_seen_q | b0_wr_q;
    end

    // ----
    // assertions
    // ----
    col_stable_a: assert property (
        b0_seen_q && !$past(b0_wr_q) |-> $stable(DRAM_COL_BITS_O) && $stable(DRAM_WAIT_O))
        else $error("geometry moved unwritten");
    sel_onehot_a: assert property ($onehot0(BANK_SEL_O))
        else $error("both banks selected");
    refuse_quiet_a: assert property (
        CYC_REFUSED_O |-> DATA_TRANSFER_ACK_N_O && BANK_SEL_O == 2'b00)
        else $error("refused cycle answered");
    cycle_end_a: assert property (
        CYC_ADDRESS_STROBE_N_I |=> DATA_TRANSFER_ACK_N_O && BANK_SEL_O == 2'b00 && !CYC_REFUSED_O)
        else $error("cycle not cleared");
    early_ack_a: assert property (
        $fell(CYC_ADDRESS_STROBE_N_I) |=> DATA_TRANSFER_ACK_N_O)
        else $error("ack too early");
    wait_zero_a: assert property (
        $fell(CYC_ADDRESS_STROBE_N_I) ##1 (BANK_SEL_O != 2'b00 && !DRAM_WAIT_O)
        |=> !DATA_TRANSFER_ACK_N_O)
        else $error("zero wait dram ack late");
    wait_one_a: assert property (
        $fell(CYC_ADDRESS_STROBE_N_I) ##1 (BANK_SEL_O != 2'b00 && DRAM_WAIT_O)
        |=> DATA_TRANSFER_ACK_N_O ##1 !DATA_TRANSFER_ACK_N_O)
        else $error("one wait dram ack wrong");
    tas_write_a: assert property (
        !CYC_ADDRESS_STROBE_N_I && !$past(CYC_ADDRESS_STROBE_N_I) && CYC_TEST_AND_SET_I
        && $fell(CYC_READ_I) && BANK_SEL_O != 2'b00
        |=> DATA_TRANSFER_ACK_N_O ##1 !DATA_TRANSFER_ACK_N_O)
        else $error("dram write half not zero wait");
    cs_wins_a: assert property (
        $fell(CYC_ADDRESS_STROBE_N_I) && CS_HIT_I != 8'h00
        |=> BANK_SEL_O == 2'b00 ##1 !CYC_REFUSED_O)
        else $error("bank selected over chip select");
    no_space_a: assert property (
        $fell(CYC_ADDRESS_STROBE_N_I) && CS_HIT_I == 8'h00 ##1 BANK_SEL_O == 2'b00
        |=> CYC_REFUSED_O)
        else $error("unclaimed cycle not refused");

    cover property ($fell(CYC_ADDRESS_STROBE_N_I) ##1 BANK_SEL_O == 2'b01);
    cover property ($fell(CYC_ADDRESS_STROBE_N_I) ##1 BANK_SEL_O == 2'b10);
    cover property (CYC_REFUSED_O);
    cover property (CYC_TEST_AND_SET_I && $fell(CYC_READ_I));
endmodule : dbd_bank_decode_chk

// File: verification/dbd_cpu_model.sv
// processor side model: runs bus cycles and times the answers
// assumes: shares the decoder clock; status sampled 1 ns after edges
`timescale 1ns/100ps
module dbd_cpu_model
(
    input wire logic clk_i,
    input wire logic ack_n_i,
    input wire logic [1:0] sel_i,
    input wire logic refused_i,
    output logic [31:0] addr_o,
    output logic [2:0] fc_o,
    output logic read_o,
    output logic strobe_n_o,
    output logic tas_o,
    output logic [7:0] cs_o
);
    initial
    begin
        addr_o = 32'h0;
        fc_o = 3'h0;
        read_o = 1'b1;
        strobe_n_o = 1'b1;
        tas_o = 1'b0;
        cs_o = 8'h00;
    end

    // ----
    // cycle tasks
    // ----
    // edges from request to ack, -1 if none within the limit
    task automatic wait_ack(output int lat);
        lat = -1;
        for (int k = 1; k <= 20 && lat < 0; k++)
        begin
            @(posedge clk_i);
            #1;
            if (k > 1 && ack_n_i === 1'b0)
                lat = k;
        end
    endtask : wait_ack

    task automatic run(input logic [31:0] a, input logic [2:0] f, input logic r,
        input logic t, input logic [7:0] c, output int l1, output int l2,
        output logic [1:0] s, output logic rf);
        l2 = -1;
        @(posedge clk_i);
        addr_o <= a;
        fc_o <= f;
        read_o <= r;
        tas_o <= t;
        cs_o <= c;
        strobe_n_o <= 1'b0;
        wait_ack(l1);
        s = sel_i;
        rf = refused_i;
        // strobe stays low through both halves of the indivisible cycle
        if (t && l1 > 0)
        begin
            @(posedge clk_i);
            read_o <= 1'b0;
            wait_ack(l2);
        end
        @(posedge clk_i);
        strobe_n_o <= 1'b1;
        read_o <= 1'b1;
        tas_o <= 1'b0;
        cs_o <= 8'h00;
        addr_o <= ~a;
        repeat (2) @(posedge clk_i);
    endtask : run
endmodule : dbd_cpu_model

// File: verification/tb_top.sv
// self-checking bench for the dram bank decoder
// assumes: 100 MHz clock; the cycle model drives the processor side
`timescale 1ns/100ps
module tb_top
    import dbd_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [3:0] hprot = 4'h3;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready, hresp;
    logic [31:0] caddr;
    logic [2:0] cfc;
    logic cread, cstb_n, ctas, dwait, ack_n, refd;
    logic [7:0] ccs;
    logic [1:0] sel;
    logic [3:0] col;
    int n_mismatch = 0;
    int cmp_count = 0;
    int ncyc = 0;

    dbd_bank_decode DUT (.SYS_CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HPROT_I(hprot),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .CYC_ADDR_I(caddr), .CYC_FC_I(cfc), .CYC_READ_I(cread),
        .CYC_ADDRESS_STROBE_N_I(cstb_n), .CYC_TEST_AND_SET_I(ctas), .CS_HIT_I(ccs),
        .BANK_SEL_O(sel), .DRAM_COL_BITS_O(col), .DRAM_WAIT_O(dwait),
        .DATA_TRANSFER_ACK_N_O(ack_n), .CYC_REFUSED_O(refd));
    dbd_cpu_model bus (.clk_i(clk), .ack_n_i(ack_n), .sel_i(sel), .refused_i(refd),
        .addr_o(caddr), .fc_o(cfc), .read_o(cread), .strobe_n_o(cstb_n), .tas_o(ctas),
        .cs_o(ccs));

    initial
    begin
        forever #5 clk = ~clk;
    end

    // ----
    // shared tasks
    // ----
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic end_of_test();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // single ahb-lite transfer; p selects a privileged access
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic p, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hprot <= {2'b00, p, 1'b1};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask : ahb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, 1'b1, q);
        #1;
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, 1'b1, q);
        chk("register_read", e, q);
    endtask : rd

    task automatic cyc(input logic [31:0] a, input logic [2:0] f, input logic r,
        input logic t, input logic [7:0] c, input int e1, input int e2, input logic [1:0] es);
        int l1, l2;
        logic [1:0] s;
        logic rf;
        bus.run(a, f, r, t, c, l1, l2, s, rf);
        chk("ack_latency", e1, l1);
        if (t)
            chk("write_half_latency", e2, l2);
        chk("bank_select", {30'h0, es}, {30'h0, s});
        chk("refused", {31'h0, es == 2'b00 && c == 8'h00}, {31'h0, rf});
    endtask : cyc

    // ----
    // scenarios
    // ----
    task automatic t_regs();
        logic [31:0] q;
        rd(ADDR_CS_ACK, 32'hffffffff);
        wr(ADDR_CS_ACK, 32'hfffff0f3);
        wr(ADDR_LOW_B0, 32'h5a5ae604);
        wr(ADDR_HIGH_B0, 32'h00000001);
        wr(ADDR_LOW_B1, 32'h0);
        wr(ADDR_HIGH_B1, 32'h0);
        ahb(1'b1, ADDR_LOW_B0, 32'h0, 1'b0, q);
        rd(ADDR_LOW_B0, 32'h0000e604);
        ahb(1'b0, ADDR_LOW_B0, 32'h0, 1'b0, q);
        chk("user_read", 32'h0, q);
        chk("user_resp", 32'h0, {31'h0, hresp});
        rd(32'h00000100, 32'h0);
        chk("column_bits", 32'ha, {28'h0, col});
    endtask : t_regs

    task automatic t_fcodes();
        logic [2:0] cd[4] = '{3'h6, 3'h5, 3'h2, 3'h1};
        int pos[4] = '{14, 13, 10, 9};
        for (int i = 0; i < 5; i++)
        begin
            wr(ADDR_LOW_B0, i < 4 ? 32'h8004 | (32'h1 << pos[i]) : 32'h8004);
            for (int f = 0; f < 8; f++)
                cyc(32'h1000, f[2:0], 1'b1, 1'b0, 8'h00, (i < 4 && f == cd[i]) ? 2 : -1, 0,
                    (i < 4 && f == cd[i]) ? 2'b01 : 2'b00);
        end
    endtask : t_fcodes

    task automatic t_permits();
        wr(ADDR_LOW_B0, 32'h6604);
        cyc(32'h1000, 3'h5, 1'b1, 1'b0, 8'h00, -1, 0, 2'b00);
        cyc(32'h1000, 3'h5, 1'b0, 1'b0, 8'h00, 2, 0, 2'b01);
        wr(ADDR_HIGH_B0, 32'h0);
        cyc(32'h1000, 3'h5, 1'b0, 1'b0, 8'h00, -1, 0, 2'b00);
        wr(ADDR_LOW_B0, 32'he604);
        cyc(32'h1000, 3'h5, 1'b1, 1'b0, 8'h00, 2, 0, 2'b01);
        cyc(32'h1000, 3'h5, 1'b0, 1'b0, 8'h00, -1, 0, 2'b00);
    endtask : t_permits

    task automatic t_match();
        wr(ADDR_LOW_B0, 32'he6f4);
        wr(ADDR_HIGH_B0, 32'h0005);
        cyc(32'h00040000, 3'h6, 1'b1, 1'b0, 8'h00, 2, 0, 2'b01);
        cyc(32'h0005fffe, 3'h6, 1'b1, 1'b0, 8'h00, 2, 0, 2'b01);
        cyc(32'h00060000, 3'h6, 1'b1, 1'b0, 8'h00, -1, 0, 2'b00);
        cyc(32'h80040000, 3'h6, 1'b1, 1'b0, 8'h00, -1, 0, 2'b00);
        wr(ADDR_LOW_B0, 32'he614);
        wr(ADDR_HIGH_B0, 32'h0001);
        cyc(32'h7fff0000, 3'h2, 1'b1, 1'b0, 8'h00, 2, 0, 2'b01);
        cyc(32'h80000000, 3'h2, 1'b1, 1'b0, 8'h00, -1, 0, 2'b00);
    endtask : t_match

    task automatic t_waits();
        wr(ADDR_LOW_B1, 32'he60f);
        chk("column_bits", 32'ha, {28'h0, col});
        chk("dram_wait", 32'h0, {31'h0, dwait});
        wr(ADDR_LOW_B0, 32'he605);
        chk("dram_wait", 32'h1, {31'h0, dwait});
        cyc(32'h2000, 3'h1, 1'b1, 1'b0, 8'h00, 3, 0, 2'b01);
        cyc(32'h2000, 3'h1, 1'b1, 1'b1, 8'h00, 3, 2, 2'b01);
    endtask : t_waits

    task automatic t_priority();
        cyc(32'h3000, 3'h6, 1'b1, 1'b0, 8'h01, 5, 0, 2'b00);
        cyc(32'h3000, 3'h6, 1'b1, 1'b0, 8'h02, -1, 0, 2'b00);
        cyc(32'h3000, 3'h6, 1'b1, 1'b0, 8'h06, -1, 0, 2'b00);
        cyc(32'h3000, 3'h6, 1'b1, 1'b0, 8'h04, 2, 0, 2'b00);
        cyc(32'h3000, 3'h6, 1'b1, 1'b1, 8'h01, 5, 5, 2'b00);
        wr(ADDR_LOW_B0, 32'h0004);
        cyc(32'h3000, 3'h6, 1'b1, 1'b0, 8'h00, 2, 0, 2'b10);
    endtask : t_priority

    task automatic t_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CS_ACK, 32'hffffffff);
        rd(ADDR_LOW_B0, 32'h00000004);
        cyc(32'h3000, 3'h5, 1'b1, 1'b0, 8'h00, 2, 0, 2'b10);
    endtask : t_reset

    // ----
    // main sequence and hang guard
    // ----
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_fcodes();
        t_permits();
        t_match();
        t_waits();
        t_priority();
        t_reset();
        end_of_test();
    end

    always @(posedge clk)
    begin
        ncyc++;
        if (ncyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
endmodule : tb_top

bind dbd_bank_decode dbd_bank_decode_chk u_chk (.*);
